// file: bench/arf_unit_model.sv
// Behavioural model of the master and channel units behind the formatter
module arf_unit_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Unit request and answer
  input wire logic unit_req_i,
  input wire logic [6:0] unit_chan_i,
  input wire logic [7:0] unit_cmd_i,
  output logic unit_ack_o,
  output logic [1:0] unit_nvals_o,
  output logic [15:0] unit_val0_o,
  output logic [15:0] unit_val1_o,
  output logic [15:0] unit_val2_o,
  output logic [7:0] unit_fault_o,
  output logic [7:0] unit_warn_o,
  output logic unit_reject_o,
  // Scenario control
  input wire logic [1:0] delay_i,
  input wire logic [6:0] inj_chan_i,
  input wire logic [7:0] inj_fault_i,
  input wire logic [7:0] inj_warn_i,
  input wire logic inj_reject_i,
  output logic [15:0] n_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_cnt;
  logic hit;
  logic [15:0] chan16;
  assign hit = (unit_chan_i == inj_chan_i);
  assign chan16 = {9'h000, unit_chan_i};
  // Answer after a chosen delay; outside the pulse and the delay count every answer line but the ack toggles
  always @(negedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      n_ack_o <= 16'h0000;
      unit_nvals_o <= 2'h3;
      unit_val0_o <= 16'h5a5a;
      unit_val1_o <= 16'ha5a5;
      unit_val2_o <= 16'h3c3c;
      unit_fault_o <= 8'h55;
      unit_warn_o <= 8'haa;
      unit_reject_o <= 1'b1;
    end else if (unit_ack_o || !unit_req_i) begin
      unit_ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      unit_nvals_o <= ~unit_nvals_o;
      unit_val0_o <= ~unit_val0_o;
      unit_val1_o <= ~unit_val1_o;
      unit_val2_o <= ~unit_val2_o;
      unit_fault_o <= ~unit_fault_o;
      unit_warn_o <= ~unit_warn_o;
      unit_reject_o <= ~unit_reject_o;
    end else if (wait_cnt != delay_i) begin
      wait_cnt <= wait_cnt + 2'h1;
    end else begin
      unit_ack_o <= 1'b1;
      n_ack_o <= n_ack_o + 16'h0001;
      unit_nvals_o <= (unit_cmd_i == 8'h63) ? 2'h0 :
        (unit_cmd_i == 8'h7a) ? 2'h3 : 2'h1;
      unit_val0_o <= chan16;
      unit_val1_o <= 16'h0064 + chan16;
      unit_val2_o <= 16'h00c8 + chan16;
      unit_fault_o <= hit ? inj_fault_i : 8'h00;
      unit_warn_o <= hit ? inj_warn_i : 8'h00;
      unit_reject_o <= hit & inj_reject_i;
    end
  end
endmodule : arf_unit_model

// file: bench/testbench.sv
// Self-checking bench for the response formatter
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] C_Q = 8'h71;
  localparam logic [7:0] C_Z = 8'h7a;
  localparam logic [7:0] C_R = 8'h72;
  localparam logic [7:0] C_H = 8'h68;
  localparam logic [7:0] C_C = 8'h63;
  localparam logic [31:1] INST = 31'h0000_0017;
  logic mclk_i, rst_i, cmd_valid_i, cmd_ready_o, cmd_has_chan_i;
  logic cmd_has_cmd_i, cmd_has_value_i, unit_req_o, unit_ack_i;
  logic unit_reject_i, tx_valid_o, tx_ready_i, terse_o, inj_reject;
  logic [15:0] cmd_chan_i, cmd_value1_i, unit_val0_i, unit_val1_i;
  logic [15:0] unit_val2_i, n_ack, acks;
  logic [7:0] cmd_char_i, unit_cmd_o, unit_fault_i, unit_warn_i, tx_data_o;
  logic [7:0] inj_fault, inj_warn;
  logic [6:0] unit_chan_o, inj_chan;
  logic [1:0] unit_nvals_i, unit_delay;
  logic [arf_pkg::NCHAN:1] installed_i;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h83bd_eee8;
  int failures, n_tests, cycles, ret_ch;
  bit terse;
  assign installed_i = INST;

  arf_formatter dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_has_chan_i(cmd_has_chan_i), .cmd_chan_i(cmd_chan_i),
    .cmd_has_cmd_i(cmd_has_cmd_i), .cmd_char_i(cmd_char_i),
    .cmd_has_value_i(cmd_has_value_i), .cmd_value1_i(cmd_value1_i),
    .installed_i(installed_i), .unit_req_o(unit_req_o),
    .unit_chan_o(unit_chan_o), .unit_cmd_o(unit_cmd_o),
    .unit_ack_i(unit_ack_i), .unit_nvals_i(unit_nvals_i),
    .unit_val0_i(unit_val0_i), .unit_val1_i(unit_val1_i),
    .unit_val2_i(unit_val2_i), .unit_fault_i(unit_fault_i),
    .unit_warn_i(unit_warn_i), .unit_reject_i(unit_reject_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .terse_o(terse_o));

  arf_unit_model unit_u (.mclk_i(mclk_i), .rst_i(rst_i),
    .unit_req_i(unit_req_o), .unit_chan_i(unit_chan_o),
    .unit_cmd_i(unit_cmd_o), .unit_ack_o(unit_ack_i),
    .unit_nvals_o(unit_nvals_i), .unit_val0_o(unit_val0_i),
    .unit_val1_o(unit_val1_i), .unit_val2_o(unit_val2_i),
    .unit_fault_o(unit_fault_i), .unit_warn_o(unit_warn_i),
    .unit_reject_o(unit_reject_i), .delay_i(unit_delay),
    .inj_chan_i(inj_chan), .inj_fault_i(inj_fault),
    .inj_warn_i(inj_warn), .inj_reject_i(inj_reject), .n_ack_o(n_ack));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic put_num(input int v);
    logic [7:0] d[$];
    do begin
      d.push_front(arf_pkg::CHR_ZERO + 8'(v % 10));
      v = v / 10;
    end while (v > 0);
    foreach (d[i])
      exp_q.push_back(d[i]);
  endtask : put_num

  // Expected reply of one unit; model values are chan, chan+100, chan+200
  task automatic exp_unit(input int ch, input logic [7:0] c, input int code);
    int nv;
    nv = (c == C_C) ? 0 : (c == C_Z) ? 3 : 1;
    if (code != 0 && nv == 3)
      nv = 2;
    put_num(ch);
    exp_q.push_back(c);
    for (int i = 0; i < nv; i++) begin
      if (i > 0)
        exp_q.push_back(arf_pkg::CHR_COMMA);
      put_num(ch + 100 * i);
    end
    if (code != 0) begin
      exp_q.push_back(arf_pkg::CHR_STAR);
      put_num(code);
    end
  endtask : exp_unit

  task automatic send(input logic hc, input logic [15:0] ch,
    input logic [7:0] c, input logic [15:0] v);
    int n;
    n = 0;
    exp_q.push_back(arf_pkg::CHR_CR);
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    unit_delay = seed[5:4];
    cmd_has_chan_i = hc;
    cmd_chan_i = ch;
    cmd_has_cmd_i = (c != 8'h00);
    cmd_char_i = c;
    cmd_has_value_i = (c == C_H || c == C_R);
    cmd_value1_i = v;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    // Nothing more goes out until the reply's CR is back
    while (exp_q.size() != 0 && n < 2000) begin
      @(negedge mclk_i);
      n++;
    end
    check("reply complete", 16'(exp_q.size()), 16'h0000);
  endtask : send

  task automatic one(input logic hc, input logic [15:0] ch,
    input logic [7:0] c, input logic [15:0] v, input int code);
    if (hc)
      ret_ch = (ch > 16'h0063) ? 99 : int'(ch);
    if (c != 8'h00 && !(terse && code == 0)) begin
      if (ret_ch == 0) begin
        for (int k = 1; k <= 31; k++) begin
          if (INST[k] && exp_q.size() != 0)
            exp_q.push_back(arf_pkg::CHR_SEMI);
          if (INST[k])
            exp_unit(k, c, code);
        end
      end else if (ret_ch == 99 || (ret_ch <= 31 && INST[ret_ch])) begin
        exp_unit(ret_ch, c, code);
      end
    end
    send(hc, ch, c, v);
  endtask : one

  task automatic done_test(input string name);
    $display("test %s done, %0d mismatches so far", name, failures);
  endtask : done_test

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Random stalls of the byte sink
  always @(negedge mclk_i) begin
    seed = lfsr_next(seed);
    tx_ready_i = seed[0] | seed[1];
  end

  always @(posedge mclk_i) begin
    if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (exp_q.size() == 0)
        check("unsolicited byte", {8'h00, tx_data_o}, 16'h0100);
      else
        check("tx byte", {8'h00, tx_data_o}, {8'h00, exp_q.pop_front()});
    end
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 50000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    {cmd_valid_i, cmd_has_chan_i, cmd_has_cmd_i, cmd_has_value_i} = 4'h0;
    cmd_chan_i = 16'h0000;
    cmd_value1_i = 16'h0000;
    cmd_char_i = 8'h00;
    unit_delay = 2'h0;
    {inj_chan, inj_fault, inj_warn, inj_reject} = 24'h00_0000;
    ret_ch = 1;
    terse = 1'b0;
    rst_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    check("terse after reset", {15'h0000, terse_o}, 16'h0000);
    one(1'b1, 16'h0002, C_Q, 16'h0000, 0);
    one(1'b0, 16'h0000, C_Q, 16'h0000, 0);
    one(1'b0, 16'h0000, C_Z, 16'h0000, 0);
    inj_chan = 7'h02;
    inj_reject = 1'b1;
    one(1'b0, 16'h0000, C_R, 16'h0000, 2);
    inj_reject = 1'b0;
    inj_chan = 7'h01;
    inj_warn = 8'h05;
    one(1'b1, 16'h0001, C_Q, 16'h0000, 5);
    inj_warn = 8'h00;
    done_test("verbose single");
    inj_chan = 7'h03;
    inj_fault = 8'h07;
    one(1'b1, 16'h0003, C_Q, 16'h0000, 7);
    inj_fault = 8'h00;
    one(1'b0, 16'h0000, C_Q, 16'h0000, 7);
    one(1'b0, 16'h0000, C_Z, 16'h0000, 7);
    one(1'b0, 16'h0000, C_C, 16'h0000, 0);
    one(1'b0, 16'h0000, C_Q, 16'h0000, 0);
    done_test("sticky fault");
    one(1'b1, 16'h0000, C_Q, 16'h0000, 0);
    one(1'b0, 16'h0000, C_Z, 16'h0000, 0);
    one(1'b1, 16'h0096, C_Z, 16'h0000, 0);
    done_test("broadcast and master");
    terse = 1'b1;
    one(1'b1, 16'h0063, C_H, 16'h0000, 0);
    check("terse on", {15'h0000, terse_o}, 16'h0001);
    one(1'b1, 16'h0001, C_Q, 16'h0000, 0);
    one(1'b1, 16'h0000, C_Q, 16'h0000, 0);
    inj_chan = 7'h01;
    inj_reject = 1'b1;
    one(1'b1, 16'h0001, C_R, 16'h0000, 2);
    inj_reject = 1'b0;
    one(1'b0, 16'h0000, C_H, 16'h0000, 0);
    check("terse kept", {15'h0000, terse_o}, 16'h0001);
    // Values come back without a warning only after returning to verbose
    terse = 1'b0;
    one(1'b1, 16'h0063, C_H, 16'h0001, 0);
    check("terse off", {15'h0000, terse_o}, 16'h0000);
    done_test("terse mode");
    one(1'b1, 16'h0002, 8'h00, 16'h0000, 0);
    acks = n_ack;
    one(1'b1, 16'h0004, C_Q, 16'h0000, 0);
    check("no unit asked", n_ack, acks);
    done_test("empty replies");
    repeat (50) @(negedge mclk_i);
    stop_test();
  end
endmodule : testbench

// file: verilog/arf_byte_if.sv
// Byte stream with valid and ready between formatter and buffer
interface arf_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : arf_byte_if

// file: verilog/arf_formatter.sv
// Response formatter: routing, fault marking, broadcast and terse mode
// Functional notes
// - Response is channel, command, up to three values, single CR.
// - Response always carries the resolved channel number; the code sends only CR when terse and quiet or when no unit is asked.
// - Active fault or warning appends star and its number.
// - Channel fault sticks until clear-faults is sent to that channel.
// - Three-value reply with fault: fault number replaces third value.
// - Rejected value: report stored value, then star and warning 2.
// - Channel 0 addresses every installed channel unit.
// - Retained channel 0 keeps later commands broadcast.
// - Broadcast replies are joined by semicolons.
// - Broadcast ends with exactly one CR, after the last reply.
// - Terse mode without fault or warning sends only CR.
// - Terse mode with fault or warning sends the full reply.
// - Verbose after reset; mode changes only by master mode command.
// - Master commands go to master, channel ones to one or all.
// - Command without channel digits reuses previous channel.
// - Channel 99 is master; larger numbers count as 99.
// - Nothing is sent unless a complete command arrived.
module arf_formatter (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Parsed command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_has_chan_i,
  input wire logic [15:0] cmd_chan_i,
  input wire logic cmd_has_cmd_i,
  input wire logic [7:0] cmd_char_i,
  input wire logic cmd_has_value_i,
  input wire logic [15:0] cmd_value1_i,
  // Units
  input wire logic [arf_pkg::NCHAN:1] installed_i,
  output logic unit_req_o,
  output logic [6:0] unit_chan_o,
  output logic [7:0] unit_cmd_o,
  input wire logic unit_ack_i,
  input wire logic [1:0] unit_nvals_i,
  input wire logic [15:0] unit_val0_i,
  input wire logic [15:0] unit_val1_i,
  input wire logic [15:0] unit_val2_i,
  input wire logic [7:0] unit_fault_i,
  input wire logic [7:0] unit_warn_i,
  input wire logic unit_reject_i,
  // Serial transmit stream
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // Status
  output logic terse_o
);

  arf_pkg::arf_state_e state;
  arf_pkg::arf_state_e finish_st;
  logic [6:0] chan_q;
  logic [6:0] cur_chan;
  logic [6:0] rchan;
  logic [6:0] nxt_chan;
  logic nxt_found;
  logic bcast;
  logic any_out;
  logic terse;
  logic [7:0] cmd_char;
  logic [15:0] rv [0:2];
  logic [1:0] nv;
  logic [1:0] nshow;
  logic [1:0] vi;
  logic [7:0] code;
  logic [7:0] code_w;
  logic [7:0] fault_cur;
  logic [7:0] fault_now;
  logic [7:0] fault_q [1:arf_pkg::NCHAN];
  logic [19:0] bcd;
  logic [2:0] dig;
  logic [15:0] ld_val;
  logic [19:0] ld_bcd;
  logic [2:0] ld_dig;
  logic accept;
  logic ack_fire;
  logic fire;
  logic in_chan;
  logic is_clear;
  logic out_valid;
  logic [7:0] out_data;

  arf_byte_if byte_in ();
  arf_byte_if byte_out ();

  function automatic logic [19:0] arf_bcd(input logic [15:0] v);
    logic [19:0] b;
    b = '0;
    for (int i = 15; i >= 0; i--) begin
      for (int d = 0; d < 5; d++) begin
        if (b[d*4 +: 4] >= 4'h5) begin
          b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
        end
      end
      b = {b[18:0], v[i]};
    end
    return b;
  endfunction : arf_bcd

  function automatic logic [2:0] arf_lead(input logic [19:0] b);
    logic [2:0] d;
    d = 3'h0;
    for (int i = 1; i < 5; i++) begin
      if (b[i*4 +: 4] != 4'h0) begin
        d = 3'(i);
      end
    end
    return d;
  endfunction : arf_lead

  assign accept = (state == arf_pkg::S_IDLE) && cmd_valid_i;
  assign ack_fire = (state == arf_pkg::S_ROUTE) && unit_ack_i;
  assign fire = out_valid && byte_in.ready;
  assign cmd_ready_o = state == arf_pkg::S_IDLE;
  assign unit_req_o = state == arf_pkg::S_ROUTE;
  assign unit_chan_o = cur_chan;
  assign unit_cmd_o = cmd_char;
  assign terse_o = terse;
  assign finish_st = bcast ? arf_pkg::S_NEXT : arf_pkg::S_CR;

  // Resolved channel: retained when omitted, clamped to the master address
  always_comb begin
    if (!cmd_has_chan_i) begin
      rchan = chan_q;
    end else if (cmd_chan_i >= arf_pkg::CHAN_CLAMP) begin
      rchan = arf_pkg::CHAN_MASTER;
    end else begin
      rchan = cmd_chan_i[6:0];
    end
  end

  // Next installed channel above the current one, lowest first
  always_comb begin
    nxt_chan = 7'h00;
    nxt_found = 1'b0;
    for (int i = arf_pkg::NCHAN; i >= 1; i--) begin
      if (installed_i[i] && 7'(i) > cur_chan) begin
        nxt_chan = 7'(i);
        nxt_found = 1'b1;
      end
    end
  end

  // Fault or warning number for the answer being taken
  assign in_chan = cur_chan != 7'h00 && cur_chan <= arf_pkg::NCHAN_C;
  assign fault_cur = in_chan ? fault_q[cur_chan[4:0]] : 8'h00;
  assign is_clear = cmd_char == arf_pkg::CMD_CLEAR;
  always_comb begin
    if (unit_fault_i != 8'h00) begin
      fault_now = unit_fault_i;
    end else if (is_clear) begin
      fault_now = 8'h00;
    end else begin
      fault_now = fault_cur;
    end
    if (fault_now != 8'h00) begin
      code_w = fault_now;
    end else if (unit_reject_i) begin
      code_w = arf_pkg::WARN_REJECT;
    end else begin
      code_w = unit_warn_i;
    end
  end

  // Third value gives way to the fault or warning number
  assign nshow = (code != 8'h00 && nv == 2'h3) ? 2'h2 : nv;

  // Number to load when a numeric field starts
  always_comb begin
    unique case (state)
      arf_pkg::S_ROUTE, arf_pkg::S_SEMI: ld_val = {9'h000, cur_chan};
      arf_pkg::S_CMD: ld_val = rv[0];
      arf_pkg::S_COMMA: ld_val = rv[2'(vi + 2'h1)];
      arf_pkg::S_STAR: ld_val = {8'h00, code};
      default: ld_val = 16'h0000;
    endcase
  end
  assign ld_bcd = arf_bcd(ld_val);
  assign ld_dig = arf_lead(ld_bcd);

  // Character presented to the buffer
  always_comb begin
    out_valid = 1'b1;
    out_data = arf_pkg::CHR_CR;
    unique case (state)
      arf_pkg::S_IDLE, arf_pkg::S_NEXT, arf_pkg::S_ROUTE: begin
        out_valid = 1'b0;
      end
      arf_pkg::S_SEMI: out_data = arf_pkg::CHR_SEMI;
      arf_pkg::S_CHAN, arf_pkg::S_VAL, arf_pkg::S_CODE: begin
        out_data = arf_pkg::CHR_ZERO | {4'h0, bcd[{dig, 2'b00} +: 4]};
      end
      arf_pkg::S_CMD: out_data = cmd_char;
      arf_pkg::S_COMMA: out_data = arf_pkg::CHR_COMMA;
      arf_pkg::S_STAR: out_data = arf_pkg::CHR_STAR;
      arf_pkg::S_CR: out_data = arf_pkg::CHR_CR;
    endcase
  end

  // Sequencer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= arf_pkg::S_IDLE;
      cur_chan <= 7'h00;
      bcast <= 1'b0;
      any_out <= 1'b0;
      cmd_char <= 8'h00;
      rv[0] <= 16'h0000;
      rv[1] <= 16'h0000;
      rv[2] <= 16'h0000;
      nv <= 2'h0;
      code <= 8'h00;
      vi <= 2'h0;
      bcd <= '0;
      dig <= 3'h0;
    end else begin
      unique case (state)
        arf_pkg::S_IDLE: if (cmd_valid_i) begin
          cmd_char <= cmd_char_i;
          bcast <= 1'b0;
          any_out <= 1'b0;
          if (!cmd_has_cmd_i) begin
            state <= arf_pkg::S_CR;
          end else if (rchan == arf_pkg::CHAN_BCAST) begin
            bcast <= 1'b1;
            cur_chan <= 7'h00;
            state <= arf_pkg::S_NEXT;
          end else if (rchan == arf_pkg::CHAN_MASTER ||
                       (rchan <= arf_pkg::NCHAN_C &&
                        installed_i[rchan[4:0]])) begin
            cur_chan <= rchan;
            state <= arf_pkg::S_ROUTE;
          end else begin
            state <= arf_pkg::S_CR;
          end
        end
        arf_pkg::S_NEXT: begin
          if (nxt_found) begin
            cur_chan <= nxt_chan;
            state <= arf_pkg::S_ROUTE;
          end else begin
            state <= arf_pkg::S_CR;
          end
        end
        arf_pkg::S_ROUTE: if (unit_ack_i) begin
          rv[0] <= unit_val0_i;
          rv[1] <= unit_val1_i;
          rv[2] <= unit_val2_i;
          nv <= unit_nvals_i;
          code <= code_w;
          vi <= 2'h0;
          bcd <= ld_bcd;
          dig <= ld_dig;
          if (terse && code_w == 8'h00) begin
            state <= finish_st;
          end else if (any_out) begin
            state <= arf_pkg::S_SEMI;
          end else begin
            state <= arf_pkg::S_CHAN;
          end
        end
        arf_pkg::S_SEMI: if (fire) begin
          bcd <= ld_bcd;
          dig <= ld_dig;
          state <= arf_pkg::S_CHAN;
        end
        arf_pkg::S_CHAN: if (fire) begin
          if (dig != 3'h0) begin
            dig <= dig - 3'h1;
          end else begin
            any_out <= 1'b1;
            state <= arf_pkg::S_CMD;
          end
        end
        arf_pkg::S_CMD: if (fire) begin
          bcd <= ld_bcd;
          dig <= ld_dig;
          if (nshow != 2'h0) begin
            state <= arf_pkg::S_VAL;
          end else if (code != 8'h00) begin
            state <= arf_pkg::S_STAR;
          end else begin
            state <= finish_st;
          end
        end
        arf_pkg::S_VAL: if (fire) begin
          if (dig != 3'h0) begin
            dig <= dig - 3'h1;
          end else if (2'(vi + 2'h1) < nshow) begin
            state <= arf_pkg::S_COMMA;
          end else if (code != 8'h00) begin
            state <= arf_pkg::S_STAR;
          end else begin
            state <= finish_st;
          end
        end
        arf_pkg::S_COMMA: if (fire) begin
          vi <= 2'(vi + 2'h1);
          bcd <= ld_bcd;
          dig <= ld_dig;
          state <= arf_pkg::S_VAL;
        end
        arf_pkg::S_STAR: if (fire) begin
          bcd <= ld_bcd;
          dig <= ld_dig;
          state <= arf_pkg::S_CODE;
        end
        arf_pkg::S_CODE: if (fire) begin
          if (dig != 3'h0) begin
            dig <= dig - 3'h1;
          end else begin
            state <= finish_st;
          end
        end
        arf_pkg::S_CR: if (fire) begin
          bcast <= 1'b0;
          any_out <= 1'b0;
          state <= arf_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Retained channel
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_q <= arf_pkg::CHAN_RESET;
    end else if (accept) begin
      chan_q <= rchan;
    end
  end

  // Response mode, changed only by the master mode command
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      terse <= 1'b0;
    end else if (accept && cmd_has_cmd_i && cmd_has_value_i &&
                 rchan == arf_pkg::CHAN_MASTER &&
                 cmd_char_i == arf_pkg::CMD_MODE) begin
      terse <= cmd_value1_i == arf_pkg::TERSE_VAL;
    end
  end

  // Sticky fault per channel; a new fault wins over a clear
  for (genvar g = 1; g <= arf_pkg::NCHAN; g++) begin : g_fault
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        fault_q[g] <= 8'h00;
      end else if (ack_fire && cur_chan == 7'(g)) begin
        if (unit_fault_i != 8'h00) begin
          fault_q[g] <= unit_fault_i;
        end else if (is_clear) begin
          fault_q[g] <= 8'h00;
        end
      end
    end
  end

  assign byte_in.valid = out_valid;
  assign byte_in.data = out_data;
  assign tx_data_o = byte_out.data;
  assign tx_valid_o = byte_out.valid;
  assign byte_out.ready = tx_ready_i;

  arf_skid_buf u_buf (
    .mclk_i (mclk_i),
    .rst_i (rst_i),
    .in_b (byte_in),
    .out_b (byte_out)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_no_unsolicited;
    state == arf_pkg::S_IDLE |-> !out_valid;
  endproperty
  a_no_unsolicited: assert property (p_no_unsolicited)
    else $error("byte offered with no command pending");

  property p_single_cr;
    fire && out_data == arf_pkg::CHR_CR |=> state == arf_pkg::S_IDLE;
  endproperty
  a_single_cr: assert property (p_single_cr)
    else $error("carriage return did not end the response");

  property p_semi_bcast;
    state == arf_pkg::S_SEMI |-> bcast && any_out;
  endproperty
  a_semi_bcast: assert property (p_semi_bcast)
    else $error("semicolon outside a broadcast");

  property p_retain;
    accept && !cmd_has_chan_i |=> chan_q == $past(chan_q);
  endproperty
  a_retain: assert property (p_retain)
    else $error("retained channel changed");

  property p_clamp;
    accept && cmd_has_chan_i && cmd_chan_i >= arf_pkg::CHAN_CLAMP
      |=> chan_q == arf_pkg::CHAN_MASTER;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("channel above 99 not taken as 99");

  property p_bcast_kept;
    accept && cmd_has_cmd_i && !cmd_has_chan_i &&
      chan_q == arf_pkg::CHAN_BCAST |=> bcast ##1 state == arf_pkg::S_ROUTE
      || state == arf_pkg::S_CR;
  endproperty
  a_bcast_kept: assert property (p_bcast_kept)
    else $error("retained channel 0 did not broadcast");

  property p_terse_quiet;
    terse && ack_fire && code_w == 8'h00
      |=> state == arf_pkg::S_NEXT || state == arf_pkg::S_CR;
  endproperty
  a_terse_quiet: assert property (p_terse_quiet)
    else $error("terse reply without fault was echoed");

  property p_mode_hold;
    !(accept && rchan == arf_pkg::CHAN_MASTER &&
      cmd_char_i == arf_pkg::CMD_MODE) |=> terse == $past(terse);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("response mode changed without master mode command");

  property p_sticky;
    ack_fire && fault_cur != 8'h00 && !is_clear && unit_fault_i == 8'h00
      |-> code_w == fault_cur;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky fault not reported");

  property p_reject;
    ack_fire && unit_reject_i && fault_now == 8'h00
      |=> code == arf_pkg::WARN_REJECT;
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected value not flagged with warning 2");

  property p_ascend;
    state == arf_pkg::S_NEXT && nxt_found |=> cur_chan > $past(cur_chan);
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("broadcast order not ascending");

  c_bcast: cover property (state == arf_pkg::S_SEMI && fire);
  c_terse_cr: cover property (terse && state == arf_pkg::S_CR && !any_out);
  c_fault: cover property (state == arf_pkg::S_STAR && fire);
  c_stall: cover property (out_valid && !byte_in.ready);

endmodule : arf_formatter

// file: verilog/arf_pkg.sv
// Constants and state type shared by the response formatter files
package arf_pkg;

  // Characters of the response string
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_COMMA = 8'h2C;
  localparam logic [7:0] CHR_STAR = 8'h2A;
  localparam logic [7:0] CHR_SEMI = 8'h3B;
  localparam logic [7:0] CHR_ZERO = 8'h30;

  // Command characters the formatter itself looks at
  localparam logic [7:0] CMD_MODE = 8'h68;
  localparam logic [7:0] CMD_CLEAR = 8'h63;

  // Channel addressing
  localparam logic [6:0] CHAN_BCAST = 7'h00;
  localparam logic [6:0] CHAN_MASTER = 7'h63;
  localparam logic [15:0] CHAN_CLAMP = 16'h0063;
  localparam logic [6:0] CHAN_RESET = 7'h01;
  localparam int NCHAN = 31;
  localparam logic [6:0] NCHAN_C = 7'h1F;

  // Warning and mode values
  localparam logic [7:0] WARN_REJECT = 8'h02;
  localparam logic [15:0] TERSE_VAL = 16'h0000;

  // Output buffer
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE, S_NEXT, S_ROUTE, S_SEMI, S_CHAN, S_CMD,
    S_VAL, S_COMMA, S_STAR, S_CODE, S_CR
  } arf_state_e;

endpackage : arf_pkg

// file: verilog/arf_skid_buf.sv
// Two-entry byte buffer between formatter and transmitter
module arf_skid_buf (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Streams
  arf_byte_if.snk in_b,
  arf_byte_if.src out_b
);

  logic [7:0] mem [0:arf_pkg::BUF_DEPTH-1];
  logic wp;
  logic rp;
  logic [1:0] cnt;
  logic wr;
  logic rd;

  assign in_b.ready = cnt != arf_pkg::BUF_FULL;
  assign out_b.valid = cnt != 2'h0;
  assign out_b.data = mem[rp];
  assign wr = in_b.valid && in_b.ready;
  assign rd = out_b.valid && out_b.ready;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      wp <= 1'b0;
    end else if (wr) begin
      mem[wp] <= in_b.data;
      wp <= ~wp;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rp <= 1'b0;
    end else if (rd) begin
      rp <= ~rp;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 2'h0;
    end else if (wr && !rd) begin
      cnt <= cnt + 2'h1;
    end else if (rd && !wr) begin
      cnt <= cnt - 2'h1;
    end
  end

endmodule : arf_skid_buf
